// >>> hw/clk_src_pkg.sv
// Shared constants for the system clock source selection block.
// Assumes a single 100 MHz register clock and an Avalon-MM slave bus.
package clk_src_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] OFS_OSC_CTL   = 4'h0;
    localparam logic [3:0] OFS_TRIM_CFG  = 4'h4;
    localparam logic [3:0] OFS_STATUS    = 4'h8;

    // ==========================================================
    // Oscillator control fields
    localparam int         BIT_INT_EN    = 7;
    localparam int         BIT_XTAL_EN   = 6;
    localparam int         BIT_WDOG_EN   = 5;
    localparam int         BIT_PFAIL_EN  = 4;
    localparam int         BIT_WFAIL_EN  = 3;
    localparam logic [7:0] OSC_CTL_RESET = 8'hA0;
    localparam logic [7:0] UNLOCK_KEY1   = 8'hE7;
    localparam logic [7:0] UNLOCK_KEY2   = 8'h18;

    // Trim/config and status fields
    localparam int         BIT_FILTER_EN = 8;
    localparam int         BIT_PFAIL_ST  = 0;
    localparam int         BIT_WFAIL_ST  = 1;

    // ==========================================================
    // Clock source codes
    localparam logic [2:0] SEL_INT_FAST  = 3'h0;
    localparam logic [2:0] SEL_INT_SLOW  = 3'h1;
    localparam logic [2:0] SEL_XTAL      = 3'h2;
    localparam logic [2:0] SEL_WDOG      = 3'h3;
    localparam logic [2:0] SEL_EXT       = 3'h4;
    localparam int         NUM_SRC       = 5;

    typedef enum logic [1:0] {
        LOCKED    = 2'h0,
        KEY1_SEEN = 2'h1,
        UNLOCKED  = 2'h3
    } lock_state_t;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int INT_START_NS       = 25000;
    localparam int INT_START_CYCLES   = INT_START_NS / CLK_PERIOD_NS;
    localparam int PFAIL_PERIOD_NS    = 1000000;
    localparam int PFAIL_CYCLES       = PFAIL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int WDOG_FAIL_SYSCLKS  = 8004;
    localparam int TIMEOUT_W          = 17;

    function automatic logic sel_is_valid(input logic [2:0] sel);
        sel_is_valid = (sel <= SEL_EXT);
    endfunction : sel_is_valid

endpackage : clk_src_pkg

// >>> hw/edge_timeout.sv
// Counts ticks while no 'seen' event arrives; flags expiry once.
// Assumes seen is a single-cycle pulse and tick a pulse or held high, both on the same clock.
`timescale 1ns/10ps
module edge_timeout
    import clk_src_pkg::*;
#(
    parameter int LIMIT = 8004
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic tick,
    input  wire logic seen,
    output logic      expired
);
    localparam logic [TIMEOUT_W-1:0] LIM_V  = TIMEOUT_W'(LIMIT);
    localparam logic [TIMEOUT_W-1:0] LIM_M1 = TIMEOUT_W'(LIMIT - 1);

    logic [TIMEOUT_W-1:0] cnt_r;
    logic [TIMEOUT_W-1:0] cnt_nxt;
    logic                 exp_r;
    logic                 exp_nxt;

    // ==========================================================
    // Counter
    // Parks at the limit so a dead clock reports only once
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (!enable || seen) begin
            cnt_nxt = '0;
        end else if (tick && cnt_r != LIM_V) begin
            cnt_nxt = cnt_r + 1'b1;
            exp_nxt = (cnt_r == LIM_M1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;

    AST_TIMEOUT_AT_LIMIT: assert property (@(posedge clock) disable iff (!rst_n)
        exp_r |-> (cnt_r == LIM_V) && $past(enable) && !$past(seen))
        else $error("timeout flagged before limit");

endmodule : edge_timeout

// >>> hw/sysclk_glitchless_mux.sv
// Glitch-free selection among sampled source clock levels.
// Assumes src_lvl already passed a two-stage synchroniser.
`timescale 1ns/10ps
module sysclk_glitchless_mux
    import clk_src_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic [NUM_SRC-1:0] src_lvl,
    input  wire logic [2:0]         target,
    input  wire logic               allow,
    input  wire logic               force_sw,
    output logic                    sysclk_out,
    output logic [2:0]              cur_sel
);
    logic [2:0] cur_r;
    logic [2:0] cur_nxt;
    logic       out_r;
    logic       out_nxt;

    // ==========================================================
    // Switch only with both clocks low; a forced switch ignores
    // the old clock since it may be stuck high after a failure.
    always_comb begin
        cur_nxt = cur_r;
        if (target != cur_r && allow && sel_is_valid(target) && !src_lvl[target]
            && (!src_lvl[cur_r] || force_sw)) begin
            cur_nxt = target;
        end
        out_nxt = src_lvl[cur_nxt];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= SEL_INT_FAST;
            out_r <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
            out_r <= out_nxt;
        end
    end

    assign sysclk_out = out_r;
    assign cur_sel    = cur_r;

    AST_SWITCH_WHILE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(cur_r) |-> !out_r && !$past(src_lvl[cur_r]))
        else $error("clock switched while a clock was high");

    CV_SWITCH: cover property (@(posedge clock) disable iff (!rst_n) $changed(cur_r));

endmodule : sysclk_glitchless_mux

// >>> hw/system_clock_source_select.sv
// System clock source control: locked control register, trim and
// option capture, failure detection and glitch-free source switch.
// Assumes option inputs are static and on the register clock; the
// oscillator clocks arrive asynchronously and are sampled here.
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module system_clock_source_select
    import clk_src_pkg::*;
#(
    parameter int PFAIL_LIMIT = PFAIL_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        int_fast_clk,
    input  wire logic        int_slow_clk,
    input  wire logic        xtal_clk,
    input  wire logic        wdog_clk,
    input  wire logic        ext_clock_pin,
    input  wire logic        crystal_reset_disable_opt,
    input  wire logic [1:0]  opt_osc_mode,
    input  wire logic [7:0]  opt_trim,
    output logic             internal_osc_en,
    output logic             crystal_osc_en,
    output logic             wdog_osc_en,
    output logic [1:0]       osc_mode,
    output logic [7:0]       int_osc_trim,
    output logic             xtal_filter_en,
    output logic             sysclk_out,
    output logic [2:0]       sysclk_source_sel,
    output logic             primary_fail_nmi,
    output logic             wdog_fail_nmi
);
    localparam logic [11:0] START_MAX = 12'(INT_START_CYCLES);

    // ==========================================================
    // Declarations
    logic [NUM_SRC-1:0] meta_r;
    logic [NUM_SRC-1:0] sync_r;
    logic               sys_d_r;
    logic               wd_d_r;
    logic               sys_rise;
    logic               wd_rise;

    lock_state_t        lock_r,    lock_nxt;
    logic [7:0]         ctl_r,     ctl_nxt;
    logic [8:0]         trim_r,    trim_nxt;
    logic [1:0]         mode_r,    mode_nxt;
    logic               boot_r,    boot_nxt;
    logic               pfail_r,   pfail_nxt;
    logic               wfail_r,   wfail_nxt;
    logic               pnmi_r,    pnmi_nxt;
    logic               wnmi_r,    wnmi_nxt;
    logic               ack_r,     ack_nxt;
    logic [31:0]        rdata_r,   rdata_nxt;
    logic [11:0]        start_r,   start_nxt;
    logic               force_r,   force_nxt;

    logic               req;
    logic               wr_ctl;
    logic               wr_trim;
    logic               wr_stat;
    logic               p_exp;
    logic               w_exp;
    logic               p_det_en;
    logic               w_det_en;
    logic               int_ready;
    logic               mux_allow;
    logic [2:0]         cur_sel;
    logic [2:0]         src_sel_w;

    // ==========================================================
    // Source sampling
    // Two stages before any logic looks at an oscillator level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r  <= '0;
            sync_r  <= '0;
            sys_d_r <= 1'b0;
            wd_d_r  <= 1'b0;
        end else begin
            meta_r  <= {ext_clock_pin, wdog_clk, xtal_clk, int_slow_clk, int_fast_clk};
            sync_r  <= meta_r;
            sys_d_r <= sysclk_out;
            wd_d_r  <= sync_r[SEL_WDOG];
        end
    end

    assign sys_rise = sysclk_out && !sys_d_r;
    assign wd_rise  = sync_r[SEL_WDOG] && !wd_d_r;

    // ==========================================================
    // Bus decode
    // Every access waits exactly one cycle
    assign req         = read || write;
    assign waitrequest = req && !ack_r;
    assign wr_ctl      = write && ack_r && address == OFS_OSC_CTL && byteenable[0];
    assign wr_trim     = write && ack_r && address == OFS_TRIM_CFG;
    assign wr_stat     = write && ack_r && address == OFS_STATUS && byteenable[0];

    // ==========================================================
    // Failure detectors
    // Watchdog failure blinds primary detection, as recovery needs it
    assign p_det_en = ctl_r[BIT_PFAIL_EN] && !wfail_r && cur_sel != SEL_WDOG;
    assign w_det_en = ctl_r[BIT_WFAIL_EN] && ctl_r[BIT_WDOG_EN] && cur_sel != SEL_WDOG;

    edge_timeout #(.LIMIT(PFAIL_LIMIT)) u_primary_timeout (
        .clock(clock), .rst_n(rst_n), .enable(p_det_en), .tick(1'b1), .seen(sys_rise), .expired(p_exp)
    );

    edge_timeout #(.LIMIT(WDOG_FAIL_SYSCLKS)) u_wdog_timeout (
        .clock(clock), .rst_n(rst_n), .enable(w_det_en), .tick(sys_rise), .seen(wd_rise), .expired(w_exp)
    );

    // ==========================================================
    // Control, lock and status state
    always_comb begin
        lock_nxt  = lock_r;
        ctl_nxt   = ctl_r;
        trim_nxt  = trim_r;
        mode_nxt  = mode_r;
        boot_nxt  = 1'b1;
        pfail_nxt = pfail_r;
        wfail_nxt = wfail_r;
        pnmi_nxt  = 1'b0;
        wnmi_nxt  = 1'b0;
        force_nxt = 1'b0;
        if (!boot_r) begin
            ctl_nxt[BIT_XTAL_EN] = !crystal_reset_disable_opt;
            trim_nxt             = {1'b0, opt_trim};
            mode_nxt             = opt_osc_mode;
        end
        if (wr_ctl) begin
            case (lock_r)
                LOCKED: begin
                    if (writedata[7:0] == UNLOCK_KEY1) begin
                        lock_nxt = KEY1_SEEN;
                    end
                end
                KEY1_SEEN: begin
                    if (writedata[7:0] == UNLOCK_KEY2) begin
                        lock_nxt = UNLOCKED;
                    end else if (writedata[7:0] != UNLOCK_KEY1) begin
                        lock_nxt = LOCKED;
                    end
                end
                UNLOCKED: begin
                    lock_nxt          = LOCKED;
                    ctl_nxt[7:3]      = writedata[7:3];
                    if (sel_is_valid(writedata[2:0])) begin
                        ctl_nxt[2:0] = writedata[2:0];
                    end
                end
                default: begin
                    lock_nxt = LOCKED;
                end
            endcase
        end
        if (wr_trim && byteenable[0]) begin
            trim_nxt[7:0] = writedata[7:0];
        end
        if (wr_trim && byteenable[1]) begin
            trim_nxt[BIT_FILTER_EN] = writedata[BIT_FILTER_EN];
        end
        // Set beats the write-one clear in the same cycle
        if (wr_stat && writedata[BIT_PFAIL_ST]) begin
            pfail_nxt = 1'b0;
        end
        if (wr_stat && writedata[BIT_WFAIL_ST]) begin
            wfail_nxt = 1'b0;
        end
        if (p_exp) begin
            pfail_nxt = 1'b1;
            pnmi_nxt  = 1'b1;
            if (ctl_r[BIT_WDOG_EN]) begin
                ctl_nxt[2:0] = SEL_WDOG;
                force_nxt    = 1'b1;
            end
        end
        if (w_exp) begin
            wfail_nxt = 1'b1;
            wnmi_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_r  <= LOCKED;
            ctl_r   <= OSC_CTL_RESET;
            trim_r  <= '0;
            mode_r  <= '0;
            boot_r  <= 1'b0;
            pfail_r <= 1'b0;
            wfail_r <= 1'b0;
            pnmi_r  <= 1'b0;
            wnmi_r  <= 1'b0;
            force_r <= 1'b0;
        end else begin
            lock_r  <= lock_nxt;
            ctl_r   <= ctl_nxt;
            trim_r  <= trim_nxt;
            mode_r  <= mode_nxt;
            boot_r  <= boot_nxt;
            pfail_r <= pfail_nxt;
            wfail_r <= wfail_nxt;
            pnmi_r  <= pnmi_nxt;
            wnmi_r  <= wnmi_nxt;
            force_r <= force_nxt;
        end
    end

    // ==========================================================
    // Internal oscillator start-up
    // Sources on the internal oscillator are held off until ready
    always_comb begin
        start_nxt = '0;
        if (ctl_r[BIT_INT_EN]) begin
            start_nxt = (start_r == START_MAX) ? start_r : start_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            start_r <= '0;
        end else begin
            start_r <= start_nxt;
        end
    end

    assign int_ready = (start_r == START_MAX);
    assign src_sel_w = ctl_r[2:0];
    assign mux_allow = force_r || int_ready
                       || !(src_sel_w == SEL_INT_FAST || src_sel_w == SEL_INT_SLOW);

    sysclk_glitchless_mux u_mux (
        .clock(clock), .rst_n(rst_n), .src_lvl(sync_r), .target(src_sel_w),
        .allow(mux_allow), .force_sw(force_r), .sysclk_out(sysclk_out), .cur_sel(cur_sel)
    );

    // ==========================================================
    // Bus answer
    always_comb begin
        ack_nxt   = req && !ack_r;
        rdata_nxt = rdata_r;
        if (read && !ack_r) begin
            case (address)
                OFS_OSC_CTL:  rdata_nxt = {24'h0, ctl_r};
                OFS_TRIM_CFG: rdata_nxt = {23'h0, trim_r};
                OFS_STATUS:   rdata_nxt = {22'h0, mode_r, lock_r, int_ready, cur_sel, wfail_r, pfail_r};
                default:      rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign readdata          = rdata_r;
    assign internal_osc_en   = ctl_r[BIT_INT_EN];
    assign crystal_osc_en    = ctl_r[BIT_XTAL_EN];
    assign wdog_osc_en       = ctl_r[BIT_WDOG_EN];
    assign osc_mode          = mode_r;
    assign int_osc_trim      = trim_r[7:0];
    assign xtal_filter_en    = trim_r[BIT_FILTER_EN];
    assign sysclk_source_sel = cur_sel;
    assign primary_fail_nmi  = pnmi_r;
    assign wdog_fail_nmi     = wnmi_r;

    // ==========================================================
    // Checks
    AST_KEY1_ADVANCES: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctl && lock_r == LOCKED && writedata[7:0] == UNLOCK_KEY1 |=> lock_r == KEY1_SEEN)
        else $error("first key did not advance lock");

    AST_LOCKED_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctl && lock_r != UNLOCKED && !p_exp |=> $stable(ctl_r))
        else $error("locked control register changed");

    AST_RESERVED_KEEPS: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ctl && lock_r == UNLOCKED && !sel_is_valid(writedata[2:0]) && !p_exp
        |=> $stable(ctl_r[2:0]) && lock_r == LOCKED)
        else $error("reserved code changed source");

    AST_PFAIL_FORCES: assert property (@(posedge clock) disable iff (!rst_n)
        p_exp && ctl_r[BIT_WDOG_EN] |=> primary_fail_nmi && pfail_r && ctl_r[2:0] == SEL_WDOG)
        else $error("primary failure did not force watchdog clock");

    AST_WFAIL_NO_SWITCH: assert property (@(posedge clock) disable iff (!rst_n)
        w_exp && !p_exp && !wr_ctl |=> wdog_fail_nmi && wfail_r && $stable(ctl_r[2:0]))
        else $error("watchdog failure switched source");

    AST_INT_START: assert property (@(posedge clock) disable iff (!rst_n)
        internal_osc_en && !int_ready && $past(rst_n) |=> !internal_osc_en || start_r == $past(start_r) + 12'h001)
        else $error("internal oscillator start count stalled");

    AST_NO_AUTO_PWRDN: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(internal_osc_en) |-> $past(wr_ctl) && $past(lock_r) == UNLOCKED)
        else $error("internal oscillator stopped without write");

    AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
        req && !ack_r |=> !waitrequest)
        else $error("bus answer late");

    CV_UNLOCK_WRITE: cover property (@(posedge clock) disable iff (!rst_n) wr_ctl && lock_r == UNLOCKED);
    CV_PFAIL: cover property (@(posedge clock) disable iff (!rst_n) primary_fail_nmi);
    CV_WFAIL: cover property (@(posedge clock) disable iff (!rst_n) wdog_fail_nmi);

endmodule : system_clock_source_select

// >>> test/system_clock_source_select_bench.sv
// Self-checking bench for the system clock source control block.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
module system_clock_source_select_bench
    import clk_src_pkg::*;
;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
    } note_t;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        int_fast_clk = 1'b0;
    logic        int_slow_clk = 1'b0;
    logic        xtal_clk = 1'b0;
    logic        wdog_clk = 1'b0;
    logic        ext_clock_pin = 1'b0;
    logic        crystal_reset_disable_opt = 1'b0;
    logic [1:0]  opt_osc_mode;
    logic [7:0]  opt_trim;
    logic        internal_osc_en, crystal_osc_en, wdog_osc_en, xtal_filter_en;
    logic        sysclk_out, primary_fail_nmi, wdog_fail_nmi;
    logic [1:0]  osc_mode;
    logic [7:0]  int_osc_trim;
    logic [2:0]  sysclk_source_sel;
    logic [7:0]  t;
    logic        wdog_run = 1'b1;
    logic        ext_run = 1'b1;
    int          errors = 0;
    int          cmp_count = 0;
    int          seed = 48048;
    int          n;
    note_t       notes[$];
    note_t       nt;
    logic [2:0]  codes[5] = '{SEL_INT_FAST, SEL_INT_SLOW, SEL_WDOG, SEL_EXT, SEL_XTAL};

    // ==========================================================
    // Clocks; oscillators unrelated in phase, watchdog and ext pin stopped via wdog_run/ext_run
    initial forever #5 clock = ~clock;
    always #11 int_fast_clk = ~int_fast_clk;
    always #37 int_slow_clk = ~int_slow_clk;
    always #13 xtal_clk = ~xtal_clk;
    always #61 if (wdog_run) wdog_clk = ~wdog_clk;
    always #23 if (ext_run) ext_clock_pin = ~ext_clock_pin;

    system_clock_source_select #(.PFAIL_LIMIT(200)) dut_u (
        .clock, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
        .int_fast_clk, .int_slow_clk, .xtal_clk, .wdog_clk, .ext_clock_pin, .crystal_reset_disable_opt,
        .opt_osc_mode, .opt_trim, .internal_osc_en, .crystal_osc_en, .wdog_osc_en, .osc_mode,
        .int_osc_trim, .xtal_filter_en, .sysclk_out, .sysclk_source_sel, .primary_fail_nmi, .wdog_fail_nmi
    );

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // Request held until the edge at which waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic r, input logic [31:0] d, input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clock);
        address    <= a;
        read       <= r;
        write      <= ~r;
        writedata  <= d;
        byteenable <= be;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20) begin
            errors++;
            stop_test();
        end
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b0, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e & m, m});
        bus(a, 1'b1, 32'h0, 4'hF);
    endtask : rd

    task automatic ctl(input logic [7:0] v);
        wr(OFS_OSC_CTL, {24'h0, UNLOCK_KEY1});
        wr(OFS_OSC_CTL, {24'h0, UNLOCK_KEY2});
        wr(OFS_OSC_CTL, {24'h0, v});
        @(negedge clock);
    endtask : ctl

    // k: 0 source equals c, 1 primary event, 2 watchdog event, 3/4 ext/wdog pin low
    task automatic wait_on(input int k, input logic [2:0] c, input int lim);
        n = 0;
        while (!((k == 0 && sysclk_source_sel === c) || (k == 1 && primary_fail_nmi === 1'b1)
                 || (k == 2 && wdog_fail_nmi === 1'b1) || (k == 3 && ext_clock_pin === 1'b0)
                 || (k == 4 && wdog_clk === 1'b0))) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                errors++;
                stop_test();
            end
        end
    endtask : wait_on

    // ==========================================================
    // Read monitor
    always @(posedge clock) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                errors++;
                $display("mismatch t=%0t seen=%h exp=%h", $time, readdata, 32'h0);
            end else begin
                nt = notes.pop_front();
                check(readdata & nt.msk, nt.val);
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        @(posedge clock);
        opt_osc_mode <= 2'($random(seed));
        opt_trim     <= 8'($random(seed));
        repeat (11) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(negedge clock);
        check(32'({internal_osc_en, crystal_osc_en, wdog_osc_en}), 32'h7);
        check(32'({osc_mode, int_osc_trim, xtal_filter_en}), 32'({opt_osc_mode, opt_trim, 1'b0}));
        rd(OFS_OSC_CTL, 32'hE0, 32'hFF);
        rd(OFS_TRIM_CFG, {24'h0, opt_trim}, 32'h1FF);
        rd(OFS_STATUS, {22'h0, opt_osc_mode, 8'h0}, 32'h3DF);
        // Locked write must be ignored
        wr(OFS_OSC_CTL, 32'h13);
        rd(OFS_OSC_CTL, 32'hE0, 32'hFF);
        wr(OFS_OSC_CTL, {24'h0, UNLOCK_KEY1});
        rd(OFS_STATUS, 32'h40, 32'hC0);
        wr(OFS_OSC_CTL, {24'h0, UNLOCK_KEY2});
        // Crystal running since reset, so no stabilising wait is owed
        wr(OFS_OSC_CTL, 32'hE2);
        wait_on(0, SEL_XTAL, 3000);
        rd(OFS_OSC_CTL, 32'hE2, 32'hFF);
        check(32'(internal_osc_en), 32'h1);
        for (int c = 5; c < 8; c++) begin
            ctl(8'hE0 | 8'(c));
            rd(OFS_OSC_CTL, 32'hE2, 32'hFF);
            check(32'(sysclk_source_sel), 32'(SEL_XTAL));
        end
        foreach (codes[i]) begin
            ctl(8'hE0 | {5'h0, codes[i]});
            wait_on(0, codes[i], 3000);
            rd(OFS_STATUS, {27'h0, codes[i], 2'h0}, 32'h1C);
        end
        // Software trim override with filter enable
        t = 8'($random(seed));
        bus(OFS_TRIM_CFG, 1'b0, {23'h0, 1'b1, t}, 4'h3);
        rd(OFS_TRIM_CFG, {23'h0, 1'b1, t}, 32'h1FF);
        check(32'({xtal_filter_en, int_osc_trim}), 32'({1'b1, t}));
        // Power down and restart of the internal oscillator
        ctl(8'h62);
        check(32'(internal_osc_en), 32'h0);
        ctl(8'hE2);
        repeat (2300) @(posedge clock);
        rd(OFS_STATUS, 32'h0, 32'h20);
        repeat (300) @(posedge clock);
        rd(OFS_STATUS, 32'h20, 32'h20);
        // Primary failure on the external pin; crystal kept on while selected
        ctl(8'hF4);
        wait_on(0, SEL_EXT, 3000);
        wait_on(3, 3'h0, 20);
        ext_run = 1'b0;
        wait_on(1, 3'h0, 1000);
        check(32'(n > 150), 32'h1);
        check(32'(sysclk_out), 32'h0);
        wait_on(0, SEL_WDOG, 200);
        rd(OFS_OSC_CTL, 32'hF3, 32'hFF);
        rd(OFS_STATUS, 32'h1, 32'h1);
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, 32'h0, 32'h1);
        // Watchdog oscillator failure: event but no switch-over
        ext_run = 1'b1;
        ctl(8'hEC);
        wait_on(0, SEL_EXT, 3000);
        wait_on(4, 3'h0, 20);
        wdog_run = 1'b0;
        wait_on(2, 3'h0, 60000);
        check(32'(n >= 8004), 32'h1);
        check(32'(sysclk_source_sel), 32'(SEL_EXT));
        rd(OFS_STATUS, 32'h12, 32'h1E);
        stop_test();
    end
endmodule : system_clock_source_select_bench
